// [rtl/gci_params.svh]
// Register codes, subcommands, field positions and the last-subcommand limit
`ifndef GCI_PARAMS_SVH
`define GCI_PARAMS_SVH
`define GCI_CODE_CTRL 8'h00
`define GCI_CODE_HEAT 8'h02
`define GCI_CODE_MV 8'h04
`define GCI_CODE_STATUS 8'h06
`define GCI_CODE_NOMCAP 8'h08
`define GCI_CODE_FUCAP 8'h0A
`define GCI_CODE_REMCAP 8'h0C
`define GCI_CODE_FCCAP 8'h0E
`define GCI_CODE_MCUR 8'h10
`define GCI_CODE_SCUR 8'h12
`define GCI_CODE_PCUR 8'h14
`define GCI_CODE_MPWR 8'h18
`define GCI_CODE_PCT 8'h1C
`define GCI_CODE_DIE 8'h1E
`define GCI_CODE_HLTH 8'h20
`define GCI_SUB_STATUS 16'h0000
`define GCI_SUB_TYPE 16'h0001
`define GCI_SUB_FWREV 16'h0002
`define GCI_SUB_HWREV 16'h0003
`define GCI_SUB_LAST 16'h0007
`define GCI_SUB_INSERT 16'h000C
`define GCI_SUB_REMOVE 16'h000D
`define GCI_SUB_DS_REQ 16'h0011
`define GCI_SUB_DS_CAN 16'h0012
`define GCI_SUB_CFG 16'h0013
`define GCI_SUB_LOCK 16'h0020
`define GCI_SUB_FULLRST 16'h0041
`define GCI_SUB_PARTRST 16'h0042
`define GCI_LAST_LIMIT 16'h0015
`define GCI_CS_LOCKED 13
`define GCI_CS_DSPEND 6
`define GCI_CS_SLEEP 4
`define GCI_CS_CPMODE 3
`define GCI_FL_CFG 4
`define GCI_FL_PRESENT 3
`define GCI_FL_POR 5
`endif

// [rtl/gci_pkg.sv]
// Types shared by the gauge command interface
package gci_pkg;
   typedef enum logic [3:0] {
      GCI_INIT = 4'h1,
      GCI_NORMAL = 4'h2,
      GCI_SLEEP = 4'h4,
      GCI_DEEP = 4'h8
   } gci_pmode_t;
   typedef enum logic [2:0] {
      GCI_IDLE = 3'h1,
      GCI_LOW = 3'h2,
      GCI_HIGH = 3'h4
   } gci_xfer_t;
endpackage

// [rtl/gci_command_interface.sv]
// Gauge command interpreter: standard words and control subcommands
// What this block does
// - Each data item is a 16-bit word over two consecutive command codes.
// - Access is a code-select transaction then a two-byte data transaction.
// - Standard commands are accepted and answered in normal power mode.
// - When locked only control and temperature words are writable.
// - A control word write carries a subcommand that is decoded.
// - Temperature comes from internal sensor unless host supplies it.
// - Subcommand 0x0000 returns the status word, also when locked.
// - Subcommand 0x0001 returns the part-type code in both states.
// - Subcommand 0x0002 returns the firmware revision in both states.
// - Subcommand 0x0003 returns the hardware revision in both states.
// - Subcommand 0x0007 returns the previous subcommand, unlocked only.
// - Subcommand 0x000c sets cell-present when insert detect is off.
// - Subcommand 0x000d clears cell-present when insert detect is off.
// - Subcommand 0x0011 sets deep-sleep-pending in either state.
// - Subcommand 0x0012 clears deep-sleep-pending in either state.
// - Subcommand 0x0013 sets config mode flag, unlocked only.
// - Subcommand 0x0020 moves unlocked to locked, unlocked only.
// - Subcommand 0x0041 triggers a full reset, unlocked only.
// - Subcommand 0x0042 reloads config and clears config mode, unlocked.
// - Restricted subcommands issued while locked take no effect.
// - Power modes init, normal, sleep, deep sleep with auto moves.
// - Query results are read back at control codes 0x00/0x01.
// - Deep-sleep-pending clears on leaving deep sleep; only a wake event exits it.
`timescale 1ns/10ps
`include "gci_params.svh"
module gci_command_interface #(
   parameter logic [15:0] TYPE_CODE = 16'hA5A5,  // Arbitrary value
   parameter logic [15:0] FW_REV = 16'h0100,  // Arbitrary value
   parameter logic [15:0] HW_REV = 16'h00A1,  // Arbitrary value
   parameter int INIT_CYCLES = 16
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // Byte transaction port from the serial engine
   input wire logic XFER_START,
   input wire logic XFER_STOP,
   input wire logic BYTE_WR,
   input wire logic [7:0] BYTE_WDATA,
   input wire logic BYTE_RD,
   output logic [7:0] BYTE_RDATA,
   output logic BYTE_ACK,
   // Measurements from the gauging core
   input wire logic [15:0] SENSOR_HEAT,
   input wire logic [15:0] CELL_POTENTIAL,
   input wire logic [15:0] NOMINAL_CAPACITY,
   input wire logic [15:0] FULL_USABLE_CAPACITY,
   input wire logic [15:0] REMAINING_CAPACITY,
   input wire logic [15:0] FULL_CHARGE_CAPACITY,
   input wire logic [15:0] MEAN_CURRENT,
   input wire logic [15:0] STANDBY_CURRENT,
   input wire logic [15:0] PEAK_LOAD_CURRENT,
   input wire logic [15:0] MEAN_POWER,
   input wire logic [15:0] CHARGE_PCT,
   input wire logic [15:0] DIE_HEAT_READING,
   input wire logic [15:0] HEALTH_PERCENT,
   input wire logic [15:0] GAUGE_FLAGS_IN,
   // Configuration straps and power events
   input wire logic INSERT_DETECT_EN,
   input wire logic HOST_HEAT_SEL,
   input wire logic SLEEP_COND,
   input wire logic WAKE_EVENT,
   // State outputs
   output logic [3:0] POWER_MODE,
   output logic LOCKED,
   output logic CONFIG_MODE_FLAG,
   output logic CELL_PRESENT_FLAG,
   output logic DEEP_SLEEP_PENDING,
   output logic FULL_RESET_REQ,
   output logic CONFIG_RELOAD
);
   localparam int ICW = $clog2(INIT_CYCLES + 1);
   // Counter cannot serve an empty init phase
   if (INIT_CYCLES < 1) begin : gen_init_check
      $error("INIT_CYCLES must be at least 1");
   end

   gci_pkg::gci_pmode_t pmode_reg;
   gci_pkg::gci_xfer_t xfer_reg;
   logic [ICW-1:0] init_cnt_reg;
   logic [7:0] ptr_reg;
   logic [7:0] low_byte_reg;
   logic [15:0] ctrl_result_reg;
   logic [15:0] host_heat_reg;
   logic [15:0] last_sub_reg;
   logic [15:0] snap_reg;
   logic [7:0] rdata_reg;
   logic locked_reg;
   logic cfg_reg;
   logic present_reg;
   logic ds_pend_reg;
   logic full_rst_reg;
   logic reload_reg;
   logic por_reg;
   logic normal;
   logic word_done;
   logic [15:0] word_in;
   logic [7:0] word_code;
   logic sub_valid;
   logic ctrl_write;
   logic heat_write;
   logic [15:0] status_word;
   logic [15:0] flags_word;
   logic [15:0] read_word;
   logic [15:0] sub;

   assign normal = (pmode_reg == gci_pkg::GCI_NORMAL);
   assign BYTE_ACK = normal;
   assign word_in = {BYTE_WDATA, low_byte_reg};
   assign word_code = {ptr_reg[7:1], 1'b0};
   // second byte written after code select completes a word
   assign word_done = normal && BYTE_WR && (xfer_reg == gci_pkg::GCI_HIGH);
   // locked state leaves only control and heat writable
   assign ctrl_write = word_done && (word_code == `GCI_CODE_CTRL);
   // host heat write only counts when host heat is selected
   assign heat_write = word_done && (word_code == `GCI_CODE_HEAT)
      && HOST_HEAT_SEL;
   assign sub = word_in;

   always_comb begin
      status_word = 16'h0000;
      status_word[`GCI_CS_LOCKED] = locked_reg;
      status_word[`GCI_CS_DSPEND] = ds_pend_reg;
      status_word[`GCI_CS_SLEEP] = (pmode_reg == gci_pkg::GCI_SLEEP);
      status_word[`GCI_CS_CPMODE] = 1'b1;
   end

   always_comb begin
      flags_word = GAUGE_FLAGS_IN;
      flags_word[`GCI_FL_CFG] = cfg_reg;
      flags_word[`GCI_FL_PRESENT] = present_reg;
      flags_word[`GCI_FL_POR] = por_reg;
   end

   // control subcommand decode with access check
   always_comb begin
      sub_valid = 1'b1;
      case (sub)
         `GCI_SUB_STATUS, `GCI_SUB_TYPE, `GCI_SUB_FWREV, `GCI_SUB_HWREV,
         `GCI_SUB_INSERT, `GCI_SUB_REMOVE, `GCI_SUB_DS_REQ,
         `GCI_SUB_DS_CAN: begin
            sub_valid = 1'b1;
         end
         `GCI_SUB_LAST, `GCI_SUB_CFG, `GCI_SUB_LOCK, `GCI_SUB_FULLRST,
         `GCI_SUB_PARTRST: begin
            sub_valid = !locked_reg;
         end
         default: begin
            sub_valid = 1'b0;
         end
      endcase
   end

   always_comb begin
      case (word_code)
         // query result read back at control codes
         `GCI_CODE_CTRL: read_word = ctrl_result_reg;
         `GCI_CODE_HEAT: read_word = HOST_HEAT_SEL ? host_heat_reg
            : SENSOR_HEAT;
         `GCI_CODE_MV: read_word = CELL_POTENTIAL;
         `GCI_CODE_STATUS: read_word = flags_word;
         `GCI_CODE_NOMCAP: read_word = NOMINAL_CAPACITY;
         `GCI_CODE_FUCAP: read_word = FULL_USABLE_CAPACITY;
         `GCI_CODE_REMCAP: read_word = REMAINING_CAPACITY;
         `GCI_CODE_FCCAP: read_word = FULL_CHARGE_CAPACITY;
         `GCI_CODE_MCUR: read_word = MEAN_CURRENT;
         `GCI_CODE_SCUR: read_word = STANDBY_CURRENT;
         `GCI_CODE_PCUR: read_word = PEAK_LOAD_CURRENT;
         `GCI_CODE_MPWR: read_word = MEAN_POWER;
         `GCI_CODE_PCT: read_word = CHARGE_PCT;
         `GCI_CODE_DIE: read_word = DIE_HEAT_READING;
         `GCI_CODE_HLTH: read_word = HEALTH_PERCENT;
         default: read_word = 16'h0000;
      endcase
   end

   // transaction sequencing, code byte then data bytes
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         xfer_reg <= gci_pkg::GCI_IDLE;
         ptr_reg <= 8'h00;
         low_byte_reg <= 8'h00;
      end else if (XFER_START || XFER_STOP || !normal) begin
         xfer_reg <= gci_pkg::GCI_IDLE;
      end else if (BYTE_WR) begin
         case (xfer_reg)
            gci_pkg::GCI_IDLE: begin
               ptr_reg <= BYTE_WDATA;
               xfer_reg <= gci_pkg::GCI_LOW;
            end
            // low byte at even code first
            gci_pkg::GCI_LOW: begin
               low_byte_reg <= BYTE_WDATA;
               ptr_reg <= ptr_reg + 8'h01;
               xfer_reg <= gci_pkg::GCI_HIGH;
            end
            gci_pkg::GCI_HIGH: begin
               ptr_reg <= ptr_reg + 8'h01;
               xfer_reg <= gci_pkg::GCI_LOW;
            end
            default: begin
               xfer_reg <= gci_pkg::GCI_IDLE;
            end
         endcase
      end else if (BYTE_RD) begin
         ptr_reg <= ptr_reg + 8'h01;
      end
   end

   // Snapshot at low byte so the high byte matches it
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         snap_reg <= 16'h0000;
         rdata_reg <= 8'h00;
      end else if (normal && BYTE_RD) begin
         // even code gives low byte, odd the held high byte
         if (!ptr_reg[0]) begin
            snap_reg <= read_word;
            rdata_reg <= read_word[7:0];
         end else begin
            rdata_reg <= snap_reg[15:8];
         end
      end
   end
   assign BYTE_RDATA = rdata_reg;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         host_heat_reg <= 16'h0000;
      end else if (heat_write) begin
         host_heat_reg <= word_in;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl_result_reg <= 16'h0000;
      end else if (ctrl_write && sub_valid) begin
         case (sub)
            `GCI_SUB_STATUS: ctrl_result_reg <= status_word;
            `GCI_SUB_TYPE: ctrl_result_reg <= TYPE_CODE;
            `GCI_SUB_FWREV: ctrl_result_reg <= FW_REV;
            `GCI_SUB_HWREV: ctrl_result_reg <= HW_REV;
            // previous subcommand, limited below the limit code
            `GCI_SUB_LAST: ctrl_result_reg <=
               (last_sub_reg < `GCI_LAST_LIMIT) ? last_sub_reg : 16'h0000;
            default: ctrl_result_reg <= ctrl_result_reg;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         last_sub_reg <= 16'h0000;
      end else if (ctrl_write && sub_valid) begin
         last_sub_reg <= sub;
      end
   end

   // cell present set and clear by host when detect is off
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         present_reg <= 1'b0;
      end else if (ctrl_write && !INSERT_DETECT_EN) begin
         if (sub == `GCI_SUB_INSERT) begin
            present_reg <= 1'b1;
         end else if (sub == `GCI_SUB_REMOVE) begin
            present_reg <= 1'b0;
         end
      end
   end

   // deep sleep pending set, clear and auto clear
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ds_pend_reg <= 1'b0;
      end else if (ctrl_write && sub == `GCI_SUB_DS_REQ) begin
         ds_pend_reg <= 1'b1;
      end else if (ctrl_write && sub == `GCI_SUB_DS_CAN) begin
         ds_pend_reg <= 1'b0;
      end else if (pmode_reg == gci_pkg::GCI_DEEP && WAKE_EVENT) begin
         ds_pend_reg <= 1'b0;
      end
   end

   // config mode, cleared by partial reset
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         cfg_reg <= 1'b0;
         reload_reg <= 1'b0;
         por_reg <= 1'b1;
      end else begin
         reload_reg <= 1'b0;
         if (ctrl_write && sub_valid && sub == `GCI_SUB_CFG) begin
            cfg_reg <= 1'b1;
         // partial reset reloads and clears config mode
         end else if (ctrl_write && sub_valid && sub == `GCI_SUB_PARTRST)
         begin
            cfg_reg <= 1'b0;
            por_reg <= 1'b0;
            reload_reg <= 1'b1;
         end
      end
   end

   // lock transition, one way until reset
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         locked_reg <= 1'b0;
      end else if (ctrl_write && sub_valid && sub == `GCI_SUB_LOCK) begin
         locked_reg <= 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         full_rst_reg <= 1'b0;
      end else begin
         full_rst_reg <= ctrl_write && sub_valid
            && sub == `GCI_SUB_FULLRST;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         pmode_reg <= gci_pkg::GCI_INIT;
         init_cnt_reg <= '0;
      end else begin
         case (pmode_reg)
            gci_pkg::GCI_INIT: begin
               if (init_cnt_reg == ICW'(INIT_CYCLES - 1)) begin
                  pmode_reg <= gci_pkg::GCI_NORMAL;
               end else begin
                  init_cnt_reg <= init_cnt_reg + 1'b1;
               end
            end
            gci_pkg::GCI_NORMAL: begin
               if (SLEEP_COND && !XFER_START) begin
                  pmode_reg <= gci_pkg::GCI_SLEEP;
               end
            end
            gci_pkg::GCI_SLEEP: begin
               if (WAKE_EVENT || !SLEEP_COND) begin
                  pmode_reg <= gci_pkg::GCI_NORMAL;
               end else if (ds_pend_reg) begin
                  pmode_reg <= gci_pkg::GCI_DEEP;
               end
            end
            gci_pkg::GCI_DEEP: begin
               if (WAKE_EVENT) begin
                  pmode_reg <= gci_pkg::GCI_NORMAL;
               end
            end
            default: begin
               pmode_reg <= gci_pkg::GCI_INIT;
            end
         endcase
      end
   end

   assign POWER_MODE = pmode_reg;
   assign LOCKED = locked_reg;
   assign CONFIG_MODE_FLAG = cfg_reg;
   assign CELL_PRESENT_FLAG = present_reg;
   assign DEEP_SLEEP_PENDING = ds_pend_reg;
   assign FULL_RESET_REQ = full_rst_reg;
   assign CONFIG_RELOAD = reload_reg;
endmodule

// [testbench/gci_command_interface_assertions.sv]
// Port checker for the gauge command interpreter
`timescale 1ns/10ps
module gci_command_interface_assertions (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // Byte port
   input wire logic XFER_START,
   input wire logic XFER_STOP,
   input wire logic BYTE_WR,
   input wire logic [7:0] BYTE_WDATA,
   input wire logic BYTE_ACK,
   // Straps and state
   input wire logic INSERT_DETECT_EN,
   input wire logic [3:0] POWER_MODE,
   input wire logic LOCKED,
   input wire logic CONFIG_MODE_FLAG,
   input wire logic CELL_PRESENT_FLAG,
   input wire logic DEEP_SLEEP_PENDING,
   input wire logic FULL_RESET_REQ,
   input wire logic CONFIG_RELOAD
);
   logic [1:0] ph_reg;
   logic ctl_reg;
   logic [7:0] lo_reg;
   logic sub_reg;
   logic [15:0] sc_reg;
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!RESETN);
   // Pulses when a control word write completes
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ph_reg <= 2'h0;
         sub_reg <= 1'b0;
      end else begin
         sub_reg <= 1'b0;
         if (XFER_START || XFER_STOP) begin
            ph_reg <= 2'h0;
         end else if (BYTE_WR && BYTE_ACK && ph_reg != 2'h3) begin
            ph_reg <= ph_reg + 2'h1;
            if (ph_reg == 2'h0) ctl_reg <= BYTE_WDATA == 8'h00;
            if (ph_reg == 2'h1) lo_reg <= BYTE_WDATA;
            sub_reg <= ph_reg == 2'h2 && ctl_reg;
            sc_reg <= {BYTE_WDATA, lo_reg};
         end
      end
   end
   AST_ACK_NORMAL: assert property (BYTE_ACK == (POWER_MODE == 4'h2))
      else $error("byte ack outside normal mode");
   AST_DS_SET: assert property (sub_reg && sc_reg == 16'h0011
      |-> DEEP_SLEEP_PENDING) else $error("deep sleep request lost");
   AST_DS_CLR: assert property (sub_reg && sc_reg == 16'h0012
      |-> !DEEP_SLEEP_PENDING) else $error("deep sleep cancel lost");
   AST_INSERT: assert property (sub_reg && sc_reg == 16'h000C
      && !INSERT_DETECT_EN |-> CELL_PRESENT_FLAG)
      else $error("insert not applied");
   AST_REMOVE: assert property (sub_reg && sc_reg == 16'h000D
      && !INSERT_DETECT_EN |-> !CELL_PRESENT_FLAG)
      else $error("remove not applied");
   AST_LOCK: assert property (sub_reg && sc_reg == 16'h0020
      |-> LOCKED) else $error("lock not applied");
   AST_CFG: assert property (sub_reg && sc_reg == 16'h0013
      |-> CONFIG_MODE_FLAG == !LOCKED) else $error("config mode wrong");
   AST_FULLRST: assert property (sub_reg && sc_reg == 16'h0041
      |-> (FULL_RESET_REQ == !LOCKED) ##1 !FULL_RESET_REQ)
      else $error("full reset pulse wrong");
   AST_RELOAD: assert property (sub_reg && sc_reg == 16'h0042
      && !LOCKED |-> CONFIG_RELOAD && !CONFIG_MODE_FLAG ##1 !CONFIG_RELOAD)
      else $error("partial reset wrong");
   cover property (sub_reg && sc_reg == 16'h0020);
   cover property (POWER_MODE == 4'h8);
   cover property ($rose(CELL_PRESENT_FLAG));
endmodule
bind gci_command_interface gci_command_interface_assertions u_chk (
   .CLK(CLK), .RESETN(RESETN), .XFER_START(XFER_START),
   .XFER_STOP(XFER_STOP), .BYTE_WR(BYTE_WR), .BYTE_WDATA(BYTE_WDATA),
   .BYTE_ACK(BYTE_ACK), .INSERT_DETECT_EN(INSERT_DETECT_EN),
   .POWER_MODE(POWER_MODE), .LOCKED(LOCKED),
   .CONFIG_MODE_FLAG(CONFIG_MODE_FLAG), .CELL_PRESENT_FLAG(CELL_PRESENT_FLAG),
   .DEEP_SLEEP_PENDING(DEEP_SLEEP_PENDING), .FULL_RESET_REQ(FULL_RESET_REQ),
   .CONFIG_RELOAD(CONFIG_RELOAD));

// [testbench/gci_host_model.sv]
// Host model: byte level master of the command port
`timescale 1ns/10ps
module gci_host_model #(
   parameter int IDLE_CYCLES = 8
) (
   // Clock
   input wire logic CLK,
   // Byte port
   output logic XFER_START = 1'b0,
   output logic XFER_STOP = 1'b0,
   output logic BYTE_WR = 1'b0,
   output logic [7:0] BYTE_WDATA = 8'h00,
   output logic BYTE_RD = 1'b0,
   input wire logic [7:0] BYTE_RDATA
);
   task automatic frame_start();
      XFER_START <= 1'b1;
      @(posedge CLK);
      XFER_START <= 1'b0;
   endtask
   task automatic put_byte(input logic [7:0] b);
      BYTE_WR <= 1'b1;
      BYTE_WDATA <= b;
      @(posedge CLK);
   endtask
   task automatic frame_stop();
      BYTE_WR <= 1'b0;
      BYTE_WDATA <= ~BYTE_WDATA;
      XFER_STOP <= 1'b1;
      @(posedge CLK);
      XFER_STOP <= 1'b0;
      repeat (IDLE_CYCLES) @(posedge CLK);
   endtask
   task automatic wr_word(input logic [7:0] code, input logic [15:0] d);
      frame_start();
      put_byte(code);
      put_byte(d[7:0]);
      put_byte(d[15:8]);
      frame_stop();
   endtask
   task automatic rd_word(input logic [7:0] code, output logic [15:0] d);
      frame_start();
      put_byte(code);
      BYTE_WR <= 1'b0;
      frame_start();
      BYTE_RD <= 1'b1;
      @(posedge CLK);
      @(posedge CLK);
      d[7:0] = BYTE_RDATA;
      BYTE_RD <= 1'b0;
      @(posedge CLK);
      d[15:8] = BYTE_RDATA;
      frame_stop();
   endtask
endmodule

// [testbench/gci_command_interface_tb.sv]
// Self-checking bench for the gauge command interpreter
`timescale 1ns/10ps
module gci_command_interface_tb;
   localparam logic [15:0] TYPE_V = 16'h5A3C; // Arbitrary value
   localparam logic [15:0] FW_V = 16'h0203;
   localparam logic [15:0] HW_V = 16'h0011;
   logic CLK = 1'b0;
   logic RESETN = 1'b0;
   logic xs, xp, bw, br, ack, lk, cfg, pres, dsp, frst, rld;
   logic [7:0] wd, rdat;
   logic [15:0] m [13] = '{default: 16'h0000};
   logic [15:0] fin = 16'h0000;
   logic den = 1'b0;
   logic hsel = 1'b0;
   logic slp = 1'b0;
   logic wake = 1'b0;
   logic [3:0] pm;
   logic [15:0] rd;
   logic [7:0] codes [13] = '{8'h02, 8'h04, 8'h08, 8'h0A, 8'h0C, 8'h0E,
      8'h10, 8'h12, 8'h14, 8'h18, 8'h1C, 8'h1E, 8'h20};
   int n_fail = 0;
   int checks_done = 0;
   int seed = 32'h3658;
   int n_full = 0;
   int n_rld = 0;
   always #2 CLK = ~CLK;
   always @(posedge CLK) begin
      if (frst === 1'b1) n_full++;
      if (rld === 1'b1) n_rld++;
   end
   gci_command_interface #(.TYPE_CODE(TYPE_V), .FW_REV(FW_V), .HW_REV(HW_V),
      .INIT_CYCLES(6)) DUT (
      .CLK(CLK), .RESETN(RESETN), .XFER_START(xs), .XFER_STOP(xp),
      .BYTE_WR(bw), .BYTE_WDATA(wd), .BYTE_RD(br), .BYTE_RDATA(rdat),
      .BYTE_ACK(ack), .SENSOR_HEAT(m[0]), .CELL_POTENTIAL(m[1]),
      .NOMINAL_CAPACITY(m[2]), .FULL_USABLE_CAPACITY(m[3]),
      .REMAINING_CAPACITY(m[4]), .FULL_CHARGE_CAPACITY(m[5]),
      .MEAN_CURRENT(m[6]), .STANDBY_CURRENT(m[7]),
      .PEAK_LOAD_CURRENT(m[8]), .MEAN_POWER(m[9]), .CHARGE_PCT(m[10]),
      .DIE_HEAT_READING(m[11]), .HEALTH_PERCENT(m[12]),
      .GAUGE_FLAGS_IN(fin), .INSERT_DETECT_EN(den), .HOST_HEAT_SEL(hsel),
      .SLEEP_COND(slp), .WAKE_EVENT(wake), .POWER_MODE(pm), .LOCKED(lk),
      .CONFIG_MODE_FLAG(cfg), .CELL_PRESENT_FLAG(pres),
      .DEEP_SLEEP_PENDING(dsp), .FULL_RESET_REQ(frst), .CONFIG_RELOAD(rld));
   gci_host_model #(.IDLE_CYCLES(8)) host (.CLK(CLK), .XFER_START(xs),
      .XFER_STOP(xp), .BYTE_WR(bw), .BYTE_WDATA(wd), .BYTE_RD(br),
      .BYTE_RDATA(rdat));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("Checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Bounded wait for a power mode
   task automatic wait_mode(input logic [3:0] md);
      for (int i = 0; i < 300 && pm !== md; i++) @(posedge CLK);
      chk(16'(pm), 16'(md));
      if (pm !== md) stop_test();
   endtask
   task automatic sub(input logic [15:0] c);
      host.wr_word(8'h00, c);
   endtask
   task automatic qry(input logic [15:0] c, input logic [15:0] e);
      sub(c);
      host.rd_word(8'h00, rd);
      chk(rd, e);
   endtask
   function automatic logic [15:0] fl(input logic p, input logic c,
      input logic b);
      return {fin[15:6], p, c, b, fin[2:0]};
   endfunction
   function automatic logic [15:0] st(input logic l, input logic d);
      return {2'h0, l, 6'h00, d, 6'h08};
   endfunction
   initial begin
      repeat (10) @(posedge CLK);
      RESETN <= 1'b1;
      @(posedge CLK);
      chk(16'(pm), 16'h0001);
      wait_mode(4'h2);
      chk(16'(ack), 16'h0001);
      repeat (2) begin
         for (int i = 0; i < 13; i++) m[i] <= 16'($random(seed));
         fin <= 16'($random(seed));
         @(posedge CLK);
         for (int i = 0; i < 13; i++) begin
            host.rd_word(codes[i], rd);
            chk(rd, m[i]);
         end
         host.rd_word(8'h06, rd);
         chk(rd, fl(1'b1, 1'b0, 1'b0));
      end
      host.wr_word(8'h04, ~m[1]);
      host.rd_word(8'h04, rd);
      chk(rd, m[1]);
      hsel <= 1'b1;
      host.wr_word(8'h02, 16'h0BB8);
      host.rd_word(8'h02, rd);
      chk(rd, 16'h0BB8);
      qry(16'h0001, TYPE_V);
      qry(16'h0002, FW_V);
      qry(16'h0003, HW_V);
      qry(16'h0007, 16'h0003);
      sub(16'h0055);
      qry(16'h0007, 16'h0007);
      qry(16'h0000, st(1'b0, 1'b0));
      sub(16'h000C);
      host.rd_word(8'h06, rd);
      chk(rd, fl(1'b1, 1'b0, 1'b1));
      sub(16'h000D);
      chk(16'(pres), 16'h0000);
      den <= 1'b1;
      sub(16'h000C);
      chk(16'(pres), 16'h0000);
      den <= 1'b0;
      sub(16'h0011);
      qry(16'h0000, st(1'b0, 1'b1));
      sub(16'h0012);
      chk(16'(dsp), 16'h0000);
      sub(16'h0013);
      host.rd_word(8'h06, rd);
      chk(rd, fl(1'b1, 1'b1, 1'b0));
      sub(16'h0042);
      host.rd_word(8'h06, rd);
      chk(rd, fl(1'b0, 1'b0, 1'b0));
      chk(16'(n_rld), 16'h0001);
      sub(16'h0041);
      chk(16'(n_full), 16'h0001);
      sub(16'h0020);
      sub(16'h0013);
      sub(16'h0041);
      qry(16'h0000, st(1'b1, 1'b0));
      chk(16'(lk), 16'h0001);
      chk(16'({n_full[1:0], cfg}), 16'h0002);
      host.wr_word(8'h02, 16'h0C1C);
      host.rd_word(8'h02, rd);
      chk(rd, 16'h0C1C);
      sub(16'h0011);
      slp <= 1'b1;
      wait_mode(4'h8);
      chk(16'(ack), 16'h0000);
      slp <= 1'b0;
      wake <= 1'b1;
      wait_mode(4'h2);
      wake <= 1'b0;
      chk(16'(dsp), 16'h0000);
      stop_test();
   end
endmodule
